// ---- common/gtd_pkg.sv ----
package gtd_pkg;
    // apb byte addresses, one aligned word each
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_ENTRY0_LO = 8'h04;
    localparam logic [7:0] ADDR_ENTRY0_HI = 8'h08;
    localparam logic [7:0] ADDR_ENTRY1_LO = 8'h0c;
    localparam logic [7:0] ADDR_ENTRY1_HI = 8'h10;
    localparam logic [7:0] ADDR_SURF_BASE = 8'h14;
    localparam logic [7:0] ADDR_THREAD_CAP = 8'h18;
    localparam logic [7:0] ADDR_PREFETCH = 8'h1c;
    localparam logic [7:0] ADDR_STATUS = 8'h20;

    // control register fields
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_FLOAT = 1;
    localparam int CTRL_UFLOW = 2;
    localparam int CTRL_EMASK = 3;
    localparam int CTRL_ILLOP = 4;
    localparam int CTRL_SWEXC = 5;
    localparam int CTRL_PRIO = 6;
    localparam int CTRL_HWTBL = 7;
    localparam int CTRL_TAG_LSB = 8;
    localparam int CTRL_W = 12;
    localparam logic [11:0] CTRL_RESET = 12'h000;

    // thread state bit positions
    localparam int IP_ENTRY_LSB = 6;
    localparam int CR00_FLOAT = 0;
    localparam int CR00_UFLOW = 2;
    localparam int CR00_EMASK = 3;
    localparam int CR01_ILLOP = 12;
    localparam int CR01_SWEXC = 13;
    localparam int SR00_PRIO = 23;
    localparam int SR00_TAG_LSB = 24;

    // prefetch register fields
    localparam int PF_SAMP_LSB = 0;
    localparam int PF_SURF_LSB = 8;
    localparam logic [4:0] PF_SAMP_MAX = 5'h10;
    localparam logic [2:0] PF_SURF_PER_LINE = 3'h4;
    localparam logic [15:0] CAP_RESET = 16'h0001;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage : gtd_pkg

// ---- src/gtd_dispatch.sv ----
`timescale 1ns/1ps
module gtd_dispatch #(
    parameter int CNT_W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic spawn_req,
    input wire logic entry_select,
    output logic spawn_ack,
    input wire logic retire,
    output logic disp_valid,
    input wire logic disp_ready,
    output logic [31:0] disp_ip,
    output logic [7:0] disp_cr0_0,
    output logic [15:0] disp_cr0_1,
    output logic [31:0] disp_sr0_0,
    output logic [31:0] disp_sp,
    output logic [31:0] disp_sp_limit,
    output logic [31:0] disp_surface_base,
    output logic disp_high_prio,
    input wire logic mem_busy,
    output logic pf_valid,
    output logic [4:0] pf_sampler_count,
    output logic [7:0] pf_surface_field,
    output logic pf_mask_mode,
    output logic [2:0] pf_surf_per_line
);
    if (CNT_W < 2 || CNT_W > 16) begin : g_bad_width
        $error("gtd_dispatch: CNT_W must be 2..16");
    end

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_OFFER = 1'b1
    } gtd_state_e;

    function automatic logic is_addr(input logic [7:0] a,
                                     input logic [7:0] ref_a);
        is_addr = (a == ref_a);
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = is_addr(a, gtd_pkg::ADDR_CTRL)
            || is_addr(a, gtd_pkg::ADDR_ENTRY0_LO)
            || is_addr(a, gtd_pkg::ADDR_ENTRY0_HI)
            || is_addr(a, gtd_pkg::ADDR_ENTRY1_LO)
            || is_addr(a, gtd_pkg::ADDR_ENTRY1_HI)
            || is_addr(a, gtd_pkg::ADDR_SURF_BASE)
            || is_addr(a, gtd_pkg::ADDR_THREAD_CAP)
            || is_addr(a, gtd_pkg::ADDR_PREFETCH)
            || is_addr(a, gtd_pkg::ADDR_STATUS);
    endfunction

    logic [11:0] ctrl;
    logic [25:0] entry0;
    logic [15:0] entry0_hi;
    logic [25:0] entry1;
    logic [15:0] entry1_hi;
    logic [31:0] surf_base;
    logic [15:0] thread_cap;
    logic [4:0] samp_count;
    logic [7:0] surf_field;
    logic pf_pending;
    logic [CNT_W-1:0] active;
    gtd_state_e state;

    logic setup;
    logic wr_take;
    logic launch;
    logic retire_ok;
    logic pf_write;
    logic [4:0] next_samp;
    logic [CNT_W-1:0] cap_w;

    assign setup = psel && !penable;
    assign wr_take = psel && penable && pready && pwrite;
    assign pf_write = wr_take && is_addr(paddr, gtd_pkg::ADDR_PREFETCH);
    assign cap_w = thread_cap[CNT_W-1:0];
    // request taken only while enabled and below the cap
    assign launch = (state == ST_IDLE) && spawn_req
        && ctrl[gtd_pkg::CTRL_ENABLE] && (active < cap_w);
    assign retire_ok = retire && (active != '0);

    // round an illegal sampler count down to a legal one
    always_comb begin
        next_samp = {pwdata[gtd_pkg::PF_SAMP_LSB+4:gtd_pkg::PF_SAMP_LSB+2],
                     2'b00};
        if (next_samp > gtd_pkg::PF_SAMP_MAX) begin
            next_samp = gtd_pkg::PF_SAMP_MAX;
        end
    end

    // apb: one wait-free access phase, answer registered at setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            pslverr <= setup && !mapped(paddr);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= gtd_pkg::ZERO_WORD;
        end else if (setup && !pwrite) begin
            unique case (paddr)
                gtd_pkg::ADDR_CTRL: prdata <= {20'h00000, ctrl};
                gtd_pkg::ADDR_ENTRY0_LO: prdata <= {entry0, 6'h00};
                gtd_pkg::ADDR_ENTRY0_HI: prdata <= {16'h0000, entry0_hi};
                gtd_pkg::ADDR_ENTRY1_LO: prdata <= {entry1, 6'h00};
                gtd_pkg::ADDR_ENTRY1_HI: prdata <= {16'h0000, entry1_hi};
                gtd_pkg::ADDR_SURF_BASE: prdata <= surf_base;
                gtd_pkg::ADDR_THREAD_CAP: prdata <= {16'h0000, thread_cap};
                gtd_pkg::ADDR_PREFETCH:
                    prdata <= {16'h0000, surf_field, 3'h0, samp_count};
                gtd_pkg::ADDR_STATUS:
                    prdata <= {15'h0000, pf_pending,
                               16'(active)};
                default: prdata <= gtd_pkg::ZERO_WORD;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= gtd_pkg::CTRL_RESET;
            entry0 <= 26'h0000000;
            entry0_hi <= 16'h0000;
            entry1 <= 26'h0000000;
            entry1_hi <= 16'h0000;
            surf_base <= gtd_pkg::ZERO_WORD;
            thread_cap <= gtd_pkg::CAP_RESET;
            samp_count <= 5'h00;
            surf_field <= 8'h00;
        end else if (wr_take) begin
            unique case (paddr)
                gtd_pkg::ADDR_CTRL: ctrl <= pwdata[11:0];
                gtd_pkg::ADDR_ENTRY0_LO: entry0 <= pwdata[31:6];
                // upper offset kept for readback only
                gtd_pkg::ADDR_ENTRY0_HI: entry0_hi <= pwdata[15:0];
                gtd_pkg::ADDR_ENTRY1_LO: entry1 <= pwdata[31:6];
                gtd_pkg::ADDR_ENTRY1_HI: entry1_hi <= pwdata[15:0];
                gtd_pkg::ADDR_SURF_BASE: surf_base <= pwdata;
                gtd_pkg::ADDR_THREAD_CAP: thread_cap <= pwdata[15:0];
                gtd_pkg::ADDR_PREFETCH: begin
                    samp_count <= next_samp;
                    surf_field <= pwdata[gtd_pkg::PF_SURF_LSB+7:
                                         gtd_pkg::PF_SURF_LSB];
                end
                default: begin
                end
            endcase
        end
    end

    // a fresh write wins over the clear by a launch in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pf_pending <= 1'b0;
        end else if (pf_write) begin
            pf_pending <= 1'b1;
        end else if (launch) begin
            pf_pending <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active <= '0;
        end else if (launch && !retire_ok) begin
            active <= active + 1'b1;
        end else if (retire_ok && !launch) begin
            active <= active - 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            disp_valid <= 1'b0;
            spawn_ack <= 1'b0;
        end else begin
            spawn_ack <= launch;
            unique case (state)
                ST_IDLE: begin
                    if (launch) begin
                        state <= ST_OFFER;
                        disp_valid <= 1'b1;
                    end
                end
                ST_OFFER: begin
                    if (disp_ready) begin
                        state <= ST_IDLE;
                        disp_valid <= 1'b0;
                    end
                end
            endcase
        end
    end

    // thread state captured at launch, held through the offer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            disp_ip <= gtd_pkg::ZERO_WORD;
            disp_cr0_0 <= 8'h00;
            disp_cr0_1 <= 16'h0000;
            disp_sr0_0 <= gtd_pkg::ZERO_WORD;
            disp_surface_base <= gtd_pkg::ZERO_WORD;
            disp_high_prio <= 1'b0;
        end else if (launch) begin
            // low six ip bits zero; dword select 5:3 zero
            disp_ip <= {entry_select ? entry1 : entry0,
                        6'h00};
            // rounding and denorm bits stay zero
            disp_cr0_0 <= {4'h0,
                           ctrl[gtd_pkg::CTRL_EMASK],
                           ctrl[gtd_pkg::CTRL_UFLOW],
                           1'b0,
                           ctrl[gtd_pkg::CTRL_FLOAT]};
            // stack, halt and breakpoint enables stay zero
            disp_cr0_1 <= {2'b00,
                           ctrl[gtd_pkg::CTRL_SWEXC],
                           ctrl[gtd_pkg::CTRL_ILLOP],
                           12'h000};
            disp_sr0_0 <= {4'h0,
                           ctrl[gtd_pkg::CTRL_TAG_LSB+3:
                                gtd_pkg::CTRL_TAG_LSB],
                           ctrl[gtd_pkg::CTRL_PRIO],
                           23'h000000};
            disp_surface_base <= surf_base;
            disp_high_prio <= ctrl[gtd_pkg::CTRL_PRIO];
        end
    end

    // stack pointer and limit always zero for these threads
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            disp_sp <= gtd_pkg::ZERO_WORD;
            disp_sp_limit <= gtd_pkg::ZERO_WORD;
        end else begin
            disp_sp <= gtd_pkg::ZERO_WORD;
            disp_sp_limit <= gtd_pkg::ZERO_WORD;
        end
    end

    // prefetch is a hint: dropped, never retried, when memory is busy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pf_valid <= 1'b0;
            pf_sampler_count <= 5'h00;
            pf_surface_field <= 8'h00;
            pf_mask_mode <= 1'b0;
            pf_surf_per_line <= 3'h0;
        end else if (launch) begin
            pf_valid <= pf_pending && !mem_busy;
            pf_sampler_count <= samp_count;
            pf_surface_field <= surf_field;
            pf_mask_mode <= ctrl[gtd_pkg::CTRL_HWTBL];
            pf_surf_per_line <= ctrl[gtd_pkg::CTRL_HWTBL]
                ? gtd_pkg::PF_SURF_PER_LINE : 3'h0;
        end else if (disp_valid && disp_ready) begin
            pf_valid <= 1'b0;
        end
    end

    // cap as seen at launch: a lower cap written then only blocks
    a_cap_limit: assert property (
        @(posedge pclk) disable iff (!presetn)
        launch |=> (active <= $past(cap_w)) && (active != '0))
        else $error("active count passed the cap");

    a_enable_gate: assert property (
        @(posedge pclk) disable iff (!presetn)
        !ctrl[gtd_pkg::CTRL_ENABLE] |=> !$rose(spawn_ack))
        else $error("launch while stage disabled");

    a_ip_entry: assert property (
        @(posedge pclk) disable iff (!presetn)
        launch && !entry_select |=> disp_ip[31:6] == $past(entry0))
        else $error("ip does not carry entry offset");

    a_ip_low_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        disp_valid |-> disp_ip[5:3] == 3'h0)
        else $error("ip dword select not zero");

    a_entry_sel: assert property (
        @(posedge pclk) disable iff (!presetn)
        launch && entry_select |=> disp_ip[31:6] == $past(entry1))
        else $error("second entry offset not chosen");

    a_cr_bits: assert property (
        @(posedge pclk) disable iff (!presetn)
        launch |=> disp_cr0_0[0] == $past(ctrl[gtd_pkg::CTRL_FLOAT])
            && disp_cr0_0[2] == $past(ctrl[gtd_pkg::CTRL_UFLOW])
            && disp_cr0_0[3] == $past(ctrl[gtd_pkg::CTRL_EMASK])
            && disp_cr0_1[12] == $past(ctrl[gtd_pkg::CTRL_ILLOP])
            && disp_cr0_1[13] == $past(ctrl[gtd_pkg::CTRL_SWEXC]))
        else $error("control bits not copied");

    a_defaults: assert property (
        @(posedge pclk) disable iff (!presetn)
        disp_valid |-> disp_cr0_0[7:4] == 4'h0 && disp_cr0_1[11] == 1'b0
            && disp_cr0_1[15:14] == 2'b00 && disp_sp == '0
            && disp_sp_limit == '0)
        else $error("defaulted field not zero");

    a_prio_tag: assert property (
        @(posedge pclk) disable iff (!presetn)
        disp_valid |-> disp_sr0_0[23] == disp_high_prio)
        else $error("priority class mismatch");

    a_offer_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        disp_valid && !disp_ready |=> disp_valid && $stable(disp_ip)
            && $stable(disp_surface_base))
        else $error("dispatch dropped before accept");

    a_pf_once: assert property (
        @(posedge pclk) disable iff (!presetn)
        launch && !pf_pending |=> !pf_valid)
        else $error("prefetch without programming");

    a_pf_drop: assert property (
        @(posedge pclk) disable iff (!presetn)
        launch && mem_busy |=> !pf_valid)
        else $error("prefetch issued while memory busy");

    a_samp_legal: assert property (
        @(posedge pclk) disable iff (!presetn)
        samp_count[1:0] == 2'b00 && samp_count <= gtd_pkg::PF_SAMP_MAX)
        else $error("illegal sampler count");

    a_mask_four: assert property (
        @(posedge pclk) disable iff (!presetn)
        pf_valid && pf_mask_mode |-> pf_surf_per_line == 3'h4)
        else $error("mask mode per-line limit wrong");

    a_count_down: assert property (
        @(posedge pclk) disable iff (!presetn)
        retire_ok && !launch |=> active == $past(active) - 1'b1)
        else $error("retire not counted");
endmodule // gtd_dispatch

// ---- dv/gtd_eu_model.sv ----
`timescale 1ns/1ps
module gtd_eu_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic disp_valid,
    input wire logic stall,
    input wire logic hold,
    output logic disp_ready,
    output logic retire
);
    logic [7:0] resident;
    // ready one cycle after the offer, dropped at the accept edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            disp_ready <= 1'b0;
        end else begin
            disp_ready <= disp_valid && !disp_ready && !stall;
        end
    end
    // hold keeps threads resident so the stage can reach its cap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            resident <= 8'h00;
            retire <= 1'b0;
        end else begin
            retire <= (resident != 8'h00) && !hold && !retire;
            resident <= resident + 8'(disp_valid && disp_ready) - 8'(retire);
        end
    end
endmodule // gtd_eu_model

// ---- dv/geometry_thread_dispatch_state_bench.sv ----
`timescale 1ns/1ps
module geometry_thread_dispatch_state_bench;
    typedef struct packed {
        logic [11:0] ctrl;
        logic sel;
        logic [31:0] entry;
        logic [31:0] ip;
        logic [7:0] cr00;
        logic [15:0] cr01;
        logic [31:0] sr00;
    } gtd_row_s;
    gtd_row_s rows [4] = '{
        '{12'h003, 1'b0, 32'h1234_567f, 32'h1234_5640, 8'h01, 16'h0000, 32'h0},
        '{12'h5fd, 1'b1, 32'hffff_ffff, 32'hffff_ffc0, 8'h0c, 16'h3000,
          32'h0580_0000},
        '{12'ha15, 1'b0, 32'h0000_0040, 32'h0000_0040, 8'h04, 16'h1000,
          32'h0a00_0000},
        '{12'hf2b, 1'b1, 32'h8000_0000, 32'h8000_0000, 8'h09, 16'h2000,
          32'h0f00_0000}};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic spawn_req, entry_select, spawn_ack, retire, disp_valid, disp_ready;
    logic disp_high_prio, mem_busy, pf_valid, pf_mask_mode, stall, hold;
    logic [7:0] paddr, disp_cr0_0, pf_surface_field;
    logic [31:0] pwdata, prdata, disp_ip, disp_sr0_0, disp_sp, disp_sp_limit;
    logic [31:0] disp_surface_base, rd_data, s_ip, s_sr00, s_surf, s_sp;
    logic [15:0] disp_cr0_1, s_cr01;
    logic [4:0] pf_sampler_count;
    logic [2:0] pf_surf_per_line;
    logic [7:0] s_cr00;
    logic [17:0] s_pf;
    logic rd_err, s_prio;
    int mismatches, n_checks, cycles;

    gtd_dispatch u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .spawn_req(spawn_req), .entry_select(entry_select),
        .spawn_ack(spawn_ack), .retire(retire), .disp_valid(disp_valid),
        .disp_ready(disp_ready), .disp_ip(disp_ip), .disp_cr0_0(disp_cr0_0),
        .disp_cr0_1(disp_cr0_1), .disp_sr0_0(disp_sr0_0), .disp_sp(disp_sp),
        .disp_sp_limit(disp_sp_limit), .disp_surface_base(disp_surface_base),
        .disp_high_prio(disp_high_prio), .mem_busy(mem_busy),
        .pf_valid(pf_valid), .pf_sampler_count(pf_sampler_count),
        .pf_surface_field(pf_surface_field), .pf_mask_mode(pf_mask_mode),
        .pf_surf_per_line(pf_surf_per_line));
    gtd_eu_model u_eu (.pclk(pclk), .presetn(presetn),
        .disp_valid(disp_valid), .stall(stall), .hold(hold),
        .disp_ready(disp_ready), .retire(retire));

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    // answer taken at the very edge where pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic spawn(input logic sel);
        @(posedge pclk);
        spawn_req <= 1'b1;
        entry_select <= sel;
        do @(posedge pclk); while (spawn_ack !== 1'b1);
        s_ip = disp_ip;
        s_cr00 = disp_cr0_0;
        s_cr01 = disp_cr0_1;
        s_sr00 = disp_sr0_0;
        s_surf = disp_surface_base;
        s_sp = disp_sp | disp_sp_limit;
        s_prio = disp_high_prio;
        s_pf = {pf_valid, pf_sampler_count, pf_surface_field, pf_mask_mode,
                pf_surf_per_line};
        spawn_req <= 1'b0;
    endtask
    // two edges past the release catch an ack from the last held edge
    task automatic refused_req();
        int acks;
        acks = 0;
        @(posedge pclk);
        spawn_req <= 1'b1;
        for (int k = 0; k < 22; k++) begin
            @(posedge pclk);
            spawn_req <= (k < 19);
            if (spawn_ack !== 1'b0)
                acks++;
        end
        check("refused ack", acks, 0);
    endtask
    task automatic pf_case(input logic [11:0] ctrl, input logic wr,
                           input logic [31:0] pf, input logic busy,
                           input logic [17:0] msk, input logic [17:0] exp);
        apb(1'b1, gtd_pkg::ADDR_CTRL, {20'h0, ctrl});
        if (wr)
            apb(1'b1, gtd_pkg::ADDR_PREFETCH, pf);
        mem_busy <= busy;
        spawn(1'b0);
        mem_busy <= 1'b0;
        check("prefetch", {14'h0, s_pf & msk}, {14'h0, exp});
    endtask

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            wrap_up();
        end
    end

    initial begin
        {presetn, psel, penable, pwrite, spawn_req, entry_select} = '0;
        {mem_busy, stall, hold, paddr, pwdata} = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, gtd_pkg::ADDR_CTRL, 32'h0);
        check("ctrl reset", rd_data, {20'h0, gtd_pkg::CTRL_RESET});
        apb(1'b0, gtd_pkg::ADDR_THREAD_CAP, 32'h0);
        check("cap reset", rd_data, {16'h0, gtd_pkg::CAP_RESET});
        apb(1'b1, gtd_pkg::ADDR_STATUS, 32'hffff_ffff);
        apb(1'b0, gtd_pkg::ADDR_STATUS, 32'h0);
        check("status", rd_data, 32'h0);
        apb(1'b0, 8'h24, 32'h0);
        check("unmapped", {31'h0, rd_err}, 32'h1);
        foreach (rows[i]) begin
            apb(1'b1, gtd_pkg::ADDR_ENTRY0_LO,
                rows[i].sel ? ~rows[i].entry : rows[i].entry);
            apb(1'b1, gtd_pkg::ADDR_ENTRY1_LO,
                rows[i].sel ? rows[i].entry : ~rows[i].entry);
            apb(1'b1, gtd_pkg::ADDR_ENTRY0_HI, 32'h0000_ffff);
            apb(1'b1, gtd_pkg::ADDR_ENTRY1_HI, 32'h0000_ffff);
            apb(1'b1, gtd_pkg::ADDR_SURF_BASE, ~rows[i].ip);
            apb(1'b1, gtd_pkg::ADDR_CTRL, {20'h0, rows[i].ctrl});
            spawn(rows[i].sel);
            check("ip", s_ip, rows[i].ip);
            check("cr00", {24'h0, s_cr00},
                  {24'h0, rows[i].cr00});
            check("cr01", {16'h0, s_cr01},
                  {16'h0, rows[i].cr01});
            check("sr00", s_sr00, rows[i].sr00);
            check("surface", s_surf, ~rows[i].ip);
            check("stack", s_sp, 32'h0);
            check("prio", {31'h0, s_prio},
                  {31'h0, rows[i].sr00[23]});
        end
        // offer stands while the eu model stalls; no second launch
        stall <= 1'b1;
        spawn(1'b0);
        refused_req();
        check("held offer", {31'h0, disp_valid}, 32'h1);
        stall <= 1'b0;
        apb(1'b1, gtd_pkg::ADDR_CTRL, 32'h0);
        refused_req();
        apb(1'b1, gtd_pkg::ADDR_CTRL, 32'h1);
        apb(1'b1, gtd_pkg::ADDR_THREAD_CAP, 32'h2);
        hold <= 1'b1;
        spawn(1'b0);
        spawn(1'b1);
        refused_req();
        apb(1'b0, gtd_pkg::ADDR_STATUS, 32'h0);
        check("active", rd_data, 32'h2);
        hold <= 1'b0;
        spawn(1'b0);
        repeat (20) @(posedge pclk);
        apb(1'b0, gtd_pkg::ADDR_STATUS, 32'h0);
        check("drained", rd_data, 32'h0);
        // prefetch: issued, unprogrammed, clamped count in mask mode, dropped while memory busy
        pf_case(12'h001, 1'b1, 32'h5a07, 1'b0, 18'h3ffff,
                18'h245a0);
        pf_case(12'h001, 1'b0, 32'h0, 1'b0, 18'h20000, 18'h0);
        pf_case(12'h081, 1'b1, 32'hff1f, 1'b0, 18'h3ffff,
                18'h30ffc);
        pf_case(12'h001, 1'b1, 32'h010c, 1'b1, 18'h20000,
                18'h0);
        // reset mid-run, with an offer still out: all back to reset values
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        check("valid after reset", {31'h0, disp_valid}, 32'h0);
        apb(1'b0, gtd_pkg::ADDR_CTRL, 32'h0);
        check("ctrl after reset", rd_data, {20'h0, gtd_pkg::CTRL_RESET});
        apb(1'b0, gtd_pkg::ADDR_STATUS, 32'h0);
        check("status after reset", rd_data, 32'h0);
        wrap_up();
    end
endmodule // geometry_thread_dispatch_state_bench
